// *** inc/high_port_pkg.sv ***
// Package of register offsets, reset values and field positions for the high-port bank
package high_port_pkg;
  localparam logic [7:0] port4_latch_addr = 8'h84;
  localparam logic [7:0] port5_latch_addr = 8'h85;
  localparam logic [7:0] port6_latch_addr = 8'h86;
  localparam logic [7:0] port7_latch_addr = 8'h96;
  localparam logic [7:0] drive_mode_addr  = 8'hb5;
  localparam logic [7:0] latch_reset      = 8'hff;
  localparam logic [7:0] drive_mode_reset = 8'h00;
  localparam int         port4_wr_bit     = 7;
  localparam int         port4_rd_bit     = 6;
  localparam int         port4_ale_bit    = 5;
  localparam int         pullup_dis_bit   = 7;
  localparam int         ext_mem_interface_low_bit     = 1;
  localparam int         sync_stages      = 2;
endpackage

// *** verif/high_port_gpio_bank_test.sv ***
// Self-checking bench for the high-port bank
`timescale 1ns/100ps
module high_port_gpio_bank_test;
  import high_port_pkg::*;
  logic        clk, nrst, sfr_wr, sfr_rd, sfr_rmw, sfr_hit, ext_mem_active, ext_mem_read, ext_mem_muxed;
  logic        ext_mem_wr_n, ext_mem_rd_n, ext_mem_ale, ext_mem_addr_phase;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, crossbar_config_two, ext_mem_wdata, ext_mem_rdata;
  logic [15:0] ext_mem_addr;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pullup_en, ext_en, ext_val;
  int          mismatches = 0;
  int          comparisons = 0;
  high_port_gpio_bank high_port_gpio_bank_i (
    .clk                 (clk),
    .nrst                (nrst),
    .sfr_addr            (sfr_addr),
    .sfr_wdata           (sfr_wdata),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_rmw             (sfr_rmw),
    .sfr_rdata           (sfr_rdata),
    .sfr_hit             (sfr_hit),
    .crossbar_config_two (crossbar_config_two),
    .ext_mem_active      (ext_mem_active),
    .ext_mem_read        (ext_mem_read),
    .ext_mem_muxed       (ext_mem_muxed),
    .ext_mem_wr_n        (ext_mem_wr_n),
    .ext_mem_rd_n        (ext_mem_rd_n),
    .ext_mem_ale         (ext_mem_ale),
    .ext_mem_addr        (ext_mem_addr),
    .ext_mem_wdata       (ext_mem_wdata),
    .ext_mem_addr_phase  (ext_mem_addr_phase),
    .ext_mem_rdata       (ext_mem_rdata),
    .pin_in              (pin_in),
    .pin_out             (pin_out),
    .pin_oe              (pin_oe),
    .pin_pullup_en       (pin_pullup_en)
  );
  pin_partner pin_partner_i (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp, input logic hit);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    sfr_rmw <= m;
    @(posedge clk);
    sfr_rd <= 1'b0;
    sfr_rmw <= 1'b0;
    @(negedge clk);
    chk(sfr_rdata, exp);
    chk(sfr_hit, hit);
    @(posedge clk);
  endtask
  task automatic t_reset();
    chk(pin_oe, 32'h0);
    chk(pin_pullup_en, 32'hffffffff);
    rd(port4_latch_addr, 1'b1, latch_reset, 1'b1);
    rd(drive_mode_addr, 1'b0, drive_mode_reset, 1'b1);
  endtask
  task automatic t_modes();
    wr(port4_latch_addr, 8'hf0);
    chk(pin_oe[7:0], 8'h0f);
    chk(pin_pullup_en[7:0], 8'hf0);
    wr(drive_mode_addr, 8'h82);
    chk(pin_oe, 32'hf00000ff);
    chk(pin_out[7:0], 8'hf0);
  endtask
  task automatic t_pins();
    ext_en <= 32'h0000ff00;
    ext_val <= 32'h00005a00;
    repeat (4) @(posedge clk);
    rd(port5_latch_addr, 1'b0, 8'h5a, 1'b1);
    rd(port5_latch_addr, 1'b1, 8'hff, 1'b1);
    rd(8'h00, 1'b0, 8'h00, 1'b0);
    wr(8'h00, 8'h00);
    chk(pin_out[31:8], 24'hffffff);
  endtask
  task automatic t_pullup();
    crossbar_config_two <= 8'h80;
    repeat (3) @(posedge clk);
    chk(pin_pullup_en, 32'h0);
    crossbar_config_two <= 8'h00;
  endtask
  task automatic t_ext_mem_interface();
    ext_mem_active <= 1'b1;
    ext_mem_wr_n <= 1'b0;
    ext_mem_addr <= 16'hc3a5;
    ext_mem_wdata <= 8'h3c;
    repeat (3) @(posedge clk);
    chk(pin_out[31:8], 24'h3ca5c3);
    chk(pin_out[7:5], 3'b011);
    ext_mem_read <= 1'b1;
    ext_en <= 32'hff00ff00;
    ext_val <= 32'h96005a00;
    repeat (5) @(posedge clk);
    chk(pin_oe[31:24], 8'h00);
    chk(ext_mem_rdata, 8'h96);
    ext_mem_read <= 1'b0;
    ext_en <= 32'h0000ff00;
    ext_mem_muxed <= 1'b1;
    ext_mem_addr_phase <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pin_out[31:16], 16'ha5c3);
    ext_mem_active <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {nrst, sfr_wr, sfr_rd, sfr_rmw, ext_mem_active, ext_mem_read, ext_mem_muxed} = 7'h0;
    {ext_mem_wr_n, ext_mem_rd_n, ext_mem_ale, ext_mem_addr_phase} = 4'h7;
    {sfr_addr, sfr_wdata, ext_mem_wdata, ext_mem_addr} = 40'h0;
    crossbar_config_two = 8'h00;
    {ext_en, ext_val} = 64'h0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_pins();
    t_pullup();
    t_ext_mem_interface();
    tally_and_finish();
  end
endmodule

// *** verif/pin_partner.sv ***
// External circuitry model resolving the high-port pin levels
`timescale 1ns/100ps
module pin_partner (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pullup_en,
  input  wire logic [31:0] ext_en,
  input  wire logic [31:0] ext_val,
  output logic      [31:0] pin_in
);
  // Floating pin without pull-up shows inverse of last level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pin_pullup_en | ~pin_out));
endmodule

// *** verilog/high_port_gpio_bank.sv ***
// High-port GPIO bank: output latches, drive modes, pull-ups and memory-interface takeover
`timescale 1ns/100ps
module high_port_gpio_bank (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        sfr_rmw,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic [7:0]  crossbar_config_two,
  input  wire logic        ext_mem_active,
  input  wire logic        ext_mem_read,
  input  wire logic        ext_mem_muxed,
  input  wire logic        ext_mem_wr_n,
  input  wire logic        ext_mem_rd_n,
  input  wire logic        ext_mem_ale,
  input  wire logic [15:0] ext_mem_addr,
  input  wire logic [7:0]  ext_mem_wdata,
  input  wire logic        ext_mem_addr_phase,
  output logic      [7:0]  ext_mem_rdata,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  output logic      [31:0] pin_pullup_en
);
  import high_port_pkg::*;

  logic [7:0]  latch_r [4];
  logic [7:0]  high_ports_drive_mode_r;
  logic [31:0] pin_sync_lvl;

  function automatic logic [7:0] group_mode(input logic [7:0] modes, input int port);
    group_mode = {{4{modes[2*port+1]}}, {4{modes[2*port]}}};
  endfunction

  pin_sync #(.WIDTH(32)) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (pin_in),
    .sync_out (pin_sync_lvl)
  );

  // Register decode
  wire hit4 = (sfr_addr == port4_latch_addr);
  wire hit5 = (sfr_addr == port5_latch_addr);
  wire hit6 = (sfr_addr == port6_latch_addr);
  wire hit7 = (sfr_addr == port7_latch_addr);
  wire hitm = (sfr_addr == drive_mode_addr);
  wire [3:0] latch_hit = {hit7, hit6, hit5, hit4};
  wire any_hit = |latch_hit | hitm;

  // Read source: latch on read-modify-write, else pins
  wire [7:0] port_rd [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_rd
      assign port_rd[g] = sfr_rmw ? latch_r[g] : pin_sync_lvl[8*g +: 8];
    end
  endgenerate
  wire [7:0] rd_mux = hit4 ? port_rd[0] : hit5 ? port_rd[1] : hit6 ? port_rd[2] :
                      hit7 ? port_rd[3] : hitm ? high_ports_drive_mode_r : 8'h00;

  // Memory takeover per port
  wire ext_mem_interface_on = ext_mem_active;
  wire [7:0] p4_mask = ext_mem_interface_on ? 8'he0 : 8'h00;
  wire [7:0] p5_mask = (ext_mem_interface_on && !ext_mem_muxed) ? 8'hff : 8'h00;
  wire [7:0] p6_mask = ext_mem_interface_on ? 8'hff : 8'h00;
  wire [7:0] p7_mask = ext_mem_interface_on ? 8'hff : 8'h00;
  wire [7:0] p4_ext_mem_interface = {ext_mem_wr_n, ext_mem_rd_n, ext_mem_ale, 5'h00};
  wire [7:0] p5_ext_mem_interface = ext_mem_addr[15:8];
  wire [7:0] p6_ext_mem_interface = ext_mem_muxed ? ext_mem_addr[15:8] : ext_mem_addr[7:0];
  wire [7:0] p7_ext_mem_interface = (ext_mem_muxed && ext_mem_addr_phase) ? ext_mem_addr[7:0] : ext_mem_wdata;
  wire data_float = ext_mem_interface_on && ext_mem_read && !(ext_mem_muxed && ext_mem_addr_phase);

  wire [31:0] ext_mem_interface_mask = {p7_mask, p6_mask, p5_mask, p4_mask};
  wire [31:0] ext_mem_interface_val  = {p7_ext_mem_interface, p6_ext_mem_interface, p5_ext_mem_interface, p4_ext_mem_interface};
  wire [31:0] latch_all = {latch_r[3], latch_r[2], latch_r[1], latch_r[0]};
  wire [31:0] level_nxt = (ext_mem_interface_mask & ext_mem_interface_val) | (~ext_mem_interface_mask & latch_all);
  wire [31:0] pp_all = {group_mode(high_ports_drive_mode_r, 3), group_mode(high_ports_drive_mode_r, 2),
                        group_mode(high_ports_drive_mode_r, 1), group_mode(high_ports_drive_mode_r, 0)};
  wire [31:0] float_mask = data_float ? 32'hff000000 : 32'h00000000;
  wire [31:0] oe_nxt = (~level_nxt | pp_all) & ~float_mask;
  wire        pu_dis = crossbar_config_two[pullup_dis_bit];
  wire [31:0] pu_nxt = pu_dis ? 32'h00000000 : ~(oe_nxt & ~level_nxt);

  // Register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) latch_r[i] <= latch_reset;
      high_ports_drive_mode_r <= drive_mode_reset;
    end else if (sfr_wr) begin
      for (int i = 0; i < 4; i++) if (latch_hit[i]) latch_r[i] <= sfr_wdata;
      if (hitm) high_ports_drive_mode_r <= sfr_wdata;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sfr_rdata     <= 8'h00;
      sfr_hit       <= 1'b0;
      pin_out       <= 32'hffffffff;
      pin_oe        <= 32'h00000000;
      pin_pullup_en <= 32'hffffffff;
      ext_mem_rdata <= 8'h00;
    end else begin
      sfr_rdata     <= sfr_rd ? rd_mux : 8'h00;
      sfr_hit       <= (sfr_rd | sfr_wr) & any_hit;
      pin_out       <= level_nxt;
      pin_oe        <= oe_nxt;
      pin_pullup_en <= pu_nxt;
      ext_mem_rdata <= pin_sync_lvl[31:24];
    end
  end

  latch_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_wr && hit5) |=> latch_r[1] == $past(sfr_wdata))
    else $error("port5 latch missed write");
  pullup_disable_a: assert property (@(posedge clk) disable iff (!nrst)
    crossbar_config_two[pullup_dis_bit] |=> pin_pullup_en == 32'h00000000)
    else $error("pull-ups not disabled");
  pullup_contend_a: assert property (@(posedge clk) disable iff (!nrst)
    (pin_pullup_en & pin_oe & ~pin_out) == 32'h00000000)
    else $error("pull-up on pin driven low");
  open_drain_a: assert property (@(posedge clk) disable iff (!nrst)
    (!ext_mem_interface_on && !high_ports_drive_mode_r[0] && latch_r[0][0]) |=> !pin_oe[0])
    else $error("open-drain high pin driven");
  push_pull_a: assert property (@(posedge clk) disable iff (!nrst)
    (high_ports_drive_mode_r[7] && !data_float) |=> pin_oe[31:28] == 4'hf)
    else $error("push-pull group not driven");
  pin_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd && hit6 && !sfr_rmw) |=> sfr_rdata == $past(pin_sync_lvl[23:16]))
    else $error("pin read wrong");
  rmw_read_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd && hit7 && sfr_rmw) |=> sfr_rdata == $past(latch_r[3]))
    else $error("rmw read wrong");
  strobe_map_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_mem_interface_on |=> pin_out[7:5] == $past({ext_mem_wr_n, ext_mem_rd_n, ext_mem_ale}))
    else $error("strobes not on port4");
  data_float_a: assert property (@(posedge clk) disable iff (!nrst)
    data_float |=> pin_oe[31:24] == 8'h00)
    else $error("data bus driven on read");
  addr_map_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && !ext_mem_muxed) |=> pin_out[23:16] == $past(ext_mem_addr[7:0]))
    else $error("port6 low address wrong");

  // Register bank: writes land one edge on, other registers hold
  latch4_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_wr && hit4) |=> latch_r[0] == $past(sfr_wdata))
    else $error("port4 latch missed write");

  latch6_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_wr && hit6) |=> latch_r[2] == $past(sfr_wdata))
    else $error("port6 latch missed write");

  latch7_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_wr && hit7) |=> latch_r[3] == $past(sfr_wdata))
    else $error("port7 latch missed write");

  mode_write_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_wr && hitm) |=> high_ports_drive_mode_r == $past(sfr_wdata))
    else $error("drive mode missed write");

  latch_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !sfr_wr |=> latch_all == $past(latch_all))
    else $error("latch changed without write");

  mode_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (!sfr_wr || !hitm) |=> high_ports_drive_mode_r == $past(high_ports_drive_mode_r))
    else $error("drive mode changed without write");

  // Write to pin in two steps
  sequence port4_write_s;
    sfr_wr && hit4;
  endsequence

  sequence port4_pins_follow_s;
    ##2 pin_out[4:0] == $past(sfr_wdata[4:0], 2);
  endsequence

  write_to_pin_a: assert property (@(posedge clk) disable iff (!nrst)
    port4_write_s |-> port4_pins_follow_s)
    else $error("port4 write not seen on pins");

  // Read answers
  sequence mode_read_s;
    sfr_rd && hitm;
  endsequence

  sequence mode_answer_s;
    ##1 sfr_hit && sfr_rdata == $past(high_ports_drive_mode_r);
  endsequence

  mode_read_a: assert property (@(posedge clk) disable iff (!nrst)
    mode_read_s |-> mode_answer_s)
    else $error("drive mode read wrong");

  read_hit_a: assert property (@(posedge clk) disable iff (!nrst)
    ((sfr_rd || sfr_wr) && any_hit) |=> sfr_hit)
    else $error("hit flag missing");

  read_miss_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd && !any_hit) |=> (sfr_rdata == 8'h00 && !sfr_hit))
    else $error("unmapped read answered");

  read_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !sfr_rd |=> sfr_rdata == 8'h00)
    else $error("read data without read");

  pin_read4_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd && hit4 && !sfr_rmw) |=> sfr_rdata == $past(pin_sync_lvl[7:0]))
    else $error("port4 pin read wrong");

  rmw_read4_a: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_rd && hit4 && sfr_rmw) |=> sfr_rdata == $past(latch_r[0]))
    else $error("port4 rmw read wrong");

  ext_read_sync_a: assert property (@(posedge clk) disable iff (!nrst)
    1'b1 |=> ext_mem_rdata == $past(pin_sync_lvl[31:24]))
    else $error("memory read data wrong");

  // Pin drive from latches and modes
  drive_low_a: assert property (@(posedge clk) disable iff (!nrst)
    (!ext_mem_interface_on && !latch_r[0][0]) |=> (pin_oe[0] && !pin_out[0]))
    else $error("latch zero not driven low");

  push_high_a: assert property (@(posedge clk) disable iff (!nrst)
    (!ext_mem_interface_on && latch_r[3][4] && high_ports_drive_mode_r[7]) |=> (pin_oe[28] && pin_out[28]))
    else $error("push-pull one not driven high");

  latch_restore_a: assert property (@(posedge clk) disable iff (!nrst)
    !ext_mem_interface_on |=> pin_out == $past(latch_all))
    else $error("pins not from latches");

  pullup_default_a: assert property (@(posedge clk) disable iff (!nrst)
    !crossbar_config_two[pullup_dis_bit] |=> (pin_pullup_en | (pin_oe & ~pin_out)) == 32'hffffffff)
    else $error("pull-up missing");

  pullup_float_a: assert property (@(posedge clk) disable iff (!nrst)
    !crossbar_config_two[pullup_dis_bit] |=> (pin_pullup_en & ~pin_oe) == ~pin_oe)
    else $error("floating pin without pull-up");

  // Memory takeover
  port4_low_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_mem_interface_on |=> pin_out[4:0] == $past(latch_r[0][4:0]))
    else $error("port4 low bits taken over");

  port5_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && !ext_mem_muxed) |=> pin_out[15:8] == $past(ext_mem_addr[15:8]))
    else $error("port5 high address wrong");

  port5_muxed_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && ext_mem_muxed) |=> pin_out[15:8] == $past(latch_r[1]))
    else $error("port5 taken in muxed mode");

  port6_muxed_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && ext_mem_muxed) |=> pin_out[23:16] == $past(ext_mem_addr[15:8]))
    else $error("port6 high address wrong");

  port7_data_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && !ext_mem_muxed) |=> pin_out[31:24] == $past(ext_mem_wdata))
    else $error("port7 data wrong");

  port7_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && ext_mem_muxed && ext_mem_addr_phase) |=> pin_out[31:24] == $past(ext_mem_addr[7:0]))
    else $error("port7 low address wrong");

  mode_kept_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_mem_interface_on |=> (pin_oe[23:0] & $past(pp_all[23:0])) == $past(pp_all[23:0]))
    else $error("push-pull lost in memory mode");

  low_driven_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_mem_interface_on |=> (pin_oe[23:0] | pin_out[23:0]) == 24'hffffff)
    else $error("memory low level not driven");

  data_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    (ext_mem_interface_on && !data_float) |=> (pin_oe[31:24] | pin_out[31:24]) == 8'hff)
    else $error("data bus low not driven");
endmodule

// *** verilog/pin_sync.sv ***
// Two-flop synchroniser for WIDTH pin levels (a byte by default)
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage1_r <= '1;
      sync_out <= '1;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end
endmodule
